// File: logic/cpcr_pkg.sv
package cpcr_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_RESET_ID = 8'h00;
  localparam logic [7:0] IDX_REVISION = 8'h01;
  localparam logic [7:0] IDX_POWER_ONE = 8'h02;
  localparam logic [7:0] IDX_RSVD_4D = 8'h4d;
  localparam logic [7:0] IDX_SHUTDOWN_CTRL = 8'h4e;
  localparam logic [7:0] IDX_INT_STATUS = 8'h4f;
  localparam logic [7:0] IDX_INT_LEVELS = 8'h51;
  localparam logic [7:0] IDX_SHUTDOWN_CAUSE = 8'h52;
  localparam logic [7:0] IDX_RSVD_53 = 8'h53;
  localparam logic [7:0] IDX_LINE_THRESH = 8'h54;
  localparam logic [7:0] IDX_INT_MASK = 8'h90;

  // Identity values, arbitrary neutral codes
  localparam logic [15:0] DEVICE_CODE = 16'h0a5c;
  localparam logic [2:0] SILICON_REV = 3'h1;
  localparam int REV_LSB = 12;

  // Writable bits and values after reset
  localparam logic [15:0] POWER_WMASK = 16'hff17;
  localparam logic [15:0] POWER_RESET = 16'h0000;
  localparam logic [15:0] SHUTDOWN_WMASK = 16'h03c0;
  localparam logic [15:0] SHUTDOWN_RESET = 16'h0000;
  localparam logic [15:0] LINE_WMASK = 16'h00ff;
  localparam logic [15:0] LINE_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CAUSE_RESET = 16'h0000;
  localparam int SHUTDOWN_ACT_LSB = 6;
  localparam int LINE_INC_LSB = 4;

  // First power register field layout
  typedef struct packed {
    logic master_codec_enable;
    logic system_clock_gate_enable;
    logic speaker_mixer_enable;
    logic speaker_output_enable;
    logic aux_output_three_enable;
    logic aux_output_four_enable;
    logic left_headphone_enable;
    logic right_headphone_enable;
    logic [2:0] rsvd_hi;
    logic microphone_bias_enable;
    logic rsvd_lo;
    logic [1:0] mid_rail_select;
    logic analogue_reference_enable;
  } cpcr_power_s;

  // Data-phase state of the bus slave
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } cpcr_bus_e;

endpackage

// File: logic/cpcr_regs.sv
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

// How it works
// - Any write to index zero resets everything.
// - Index zero reads fixed device code.
// - Index one reads revision in bits 14:12.
// - Codec enable low holds codec in reset.
// - Speaker, mixer, output three, four enables.
// - System clock gate and headphone enables.
// - Mic bias off is high impedance.
// - Mid-rail select decodes to divider pairs.
// - Reference bit enables common analogue bias.
// - Mask bit per interrupt status position.
module cpcr_regs (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [15:0] INT_SOURCE_LEVELS,
  input wire logic [15:0] SHUTDOWN_CAUSES,
  output logic IRQ,
  output logic CODEC_REG_RESET,
  output logic SYSCLK_GATE_EN,
  output logic SPK_MIXER_EN,
  output logic SPK_OUTPUT_EN,
  output logic AUX_OUT3_EN,
  output logic AUX_OUT4_EN,
  output logic HP_LEFT_EN,
  output logic HP_RIGHT_EN,
  output logic MIC_BIAS_OUT,
  output logic MIC_BIAS_OE,
  output logic [2:0] MID_RAIL_PAIR,
  output logic ANALOGUE_REF_EN,
  output logic [3:0] SHUTDOWN_ACTION,
  output logic [3:0] LINE_THRESH_INC,
  output logic [3:0] LINE_THRESH_DEC
);

  cpcr_pkg::cpcr_bus_e bus_reg;
  logic [7:0] addr_reg;
  logic addr_ok_reg;
  logic [31:0] rdata_reg;
  logic hreadyout_reg;
  cpcr_pkg::cpcr_power_s power_reg;
  cpcr_pkg::cpcr_power_s power_next;
  logic [15:0] shutdown_reg;
  logic [15:0] line_reg;
  logic [15:0] mask_reg;
  logic [15:0] status_reg;
  logic [15:0] cause_reg;
  logic [15:0] lvl_s1, lvl_s2, lvl_s3;
  logic [15:0] cau_s1, cau_s2, cau_s3;
  logic [15:0] lvl_rise;
  logic [15:0] cau_rise;
  logic accept;
  logic wr_now;
  logic soft_reset;
  logic codec_rst_reg;
  logic [2:0] pair_reg;
  logic irq_reg;

  // Keeps only writable bits, reserved ones read as zero
  function automatic logic [15:0] merge(input logic [15:0] wmask, input logic [15:0] data);
    merge = data & wmask;
  endfunction

  // One-hot divider pair: 50k, 300k, 6.8k; 00 leaves all off
  function automatic logic [2:0] pair_decode(input logic [1:0] sel);
    case (sel)
      2'b01: pair_decode = 3'b001;
      2'b10: pair_decode = 3'b010;
      2'b11: pair_decode = 3'b100;
      default: pair_decode = 3'b000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Bus slave

  // Address phase taken only for a selected NONSEQ/SEQ with ready high
  assign accept = HSEL && HTRANS[1] && HREADY;
  assign wr_now = (bus_reg == cpcr_pkg::BUS_WRITE) && addr_ok_reg;
  assign soft_reset = wr_now && (addr_reg == cpcr_pkg::IDX_RESET_ID);

  // Data-phase sequencer; reads take one wait state so writes settle first
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      bus_reg <= cpcr_pkg::BUS_IDLE;
      addr_reg <= 8'h00;
      addr_ok_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
    end else begin
      hreadyout_reg <= 1'b1;
      case (bus_reg)
        cpcr_pkg::BUS_READ_WAIT: begin
          bus_reg <= cpcr_pkg::BUS_READ_DONE;
        end
        default: begin
          if (accept) begin
            addr_reg <= HADDR[9:2];
            addr_ok_reg <= (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'b00);
            bus_reg <= HWRITE ? cpcr_pkg::BUS_WRITE : cpcr_pkg::BUS_READ_WAIT;
            hreadyout_reg <= HWRITE;
          end else begin
            bus_reg <= cpcr_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Read data captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rdata_reg <= 32'h00000000;
    end else if (bus_reg == cpcr_pkg::BUS_READ_WAIT) begin
      rdata_reg <= 32'h00000000;
      if (addr_ok_reg) begin
        case (addr_reg)
          cpcr_pkg::IDX_RESET_ID: rdata_reg[15:0] <= cpcr_pkg::DEVICE_CODE;
          cpcr_pkg::IDX_REVISION: begin
            rdata_reg[cpcr_pkg::REV_LSB +: 3] <= cpcr_pkg::SILICON_REV;
          end
          cpcr_pkg::IDX_POWER_ONE: rdata_reg[15:0] <= power_reg;
          cpcr_pkg::IDX_SHUTDOWN_CTRL: rdata_reg[15:0] <= shutdown_reg;
          cpcr_pkg::IDX_INT_STATUS: rdata_reg[15:0] <= status_reg;
          cpcr_pkg::IDX_INT_LEVELS: rdata_reg[15:0] <= lvl_s2;
          cpcr_pkg::IDX_SHUTDOWN_CAUSE: rdata_reg[15:0] <= cause_reg;
          cpcr_pkg::IDX_LINE_THRESH: rdata_reg[15:0] <= line_reg;
          cpcr_pkg::IDX_INT_MASK: rdata_reg[15:0] <= mask_reg;
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign HRDATA = rdata_reg;
  assign HREADYOUT = hreadyout_reg;

  // Response is always OKAY
  always_ff @(posedge CLOCK) begin
    HRESP <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Control registers

  // Next value of the first power register
  always_comb begin
    power_next = power_reg;
    if (wr_now && addr_reg == cpcr_pkg::IDX_POWER_ONE) begin
      power_next = merge(cpcr_pkg::POWER_WMASK, HWDATA[15:0]);
    end
    if (soft_reset) begin
      power_next = cpcr_pkg::POWER_RESET;
    end
  end

  // Power register and the outputs decoded from it
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      power_reg <= cpcr_pkg::POWER_RESET;
      codec_rst_reg <= 1'b1;
      pair_reg <= 3'b000;
    end else begin
      power_reg <= power_next;
      codec_rst_reg <= ~power_next.master_codec_enable;
      pair_reg <= pair_decode(power_next.mid_rail_select);
    end
  end

  assign CODEC_REG_RESET = codec_rst_reg;
  assign SYSCLK_GATE_EN = power_reg.system_clock_gate_enable;
  assign SPK_MIXER_EN = power_reg.speaker_mixer_enable;
  assign SPK_OUTPUT_EN = power_reg.speaker_output_enable;
  assign AUX_OUT3_EN = power_reg.aux_output_three_enable;
  assign AUX_OUT4_EN = power_reg.aux_output_four_enable;
  assign HP_LEFT_EN = power_reg.left_headphone_enable;
  assign HP_RIGHT_EN = power_reg.right_headphone_enable;
  assign MID_RAIL_PAIR = pair_reg;
  assign ANALOGUE_REF_EN = power_reg.analogue_reference_enable;
  // Bias driven high when on, released to high impedance when off
  assign MIC_BIAS_OUT = power_reg.microphone_bias_enable;
  assign MIC_BIAS_OE = power_reg.microphone_bias_enable;

  // Shutdown action, line thresholds and interrupt mask
  always_ff @(posedge CLOCK) begin
    if (RESET || soft_reset) begin
      shutdown_reg <= cpcr_pkg::SHUTDOWN_RESET;
      line_reg <= cpcr_pkg::LINE_RESET;
      mask_reg <= cpcr_pkg::MASK_RESET;
    end else if (wr_now) begin
      if (addr_reg == cpcr_pkg::IDX_SHUTDOWN_CTRL) begin
        shutdown_reg <= merge(cpcr_pkg::SHUTDOWN_WMASK, HWDATA[15:0]);
      end
      if (addr_reg == cpcr_pkg::IDX_LINE_THRESH) begin
        line_reg <= merge(cpcr_pkg::LINE_WMASK, HWDATA[15:0]);
      end
      if (addr_reg == cpcr_pkg::IDX_INT_MASK) begin
        mask_reg <= HWDATA[15:0];
      end
    end
  end

  assign SHUTDOWN_ACTION = shutdown_reg[cpcr_pkg::SHUTDOWN_ACT_LSB +: 4];
  assign LINE_THRESH_INC = line_reg[cpcr_pkg::LINE_INC_LSB +: 4];
  assign LINE_THRESH_DEC = line_reg[3:0];

  ////////////////////////////////////////////////////////////////
  // Event capture

  // Pins cross in through two flops; third flop only for edge finding
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      lvl_s1 <= 16'h0000;
      lvl_s2 <= 16'h0000;
      lvl_s3 <= 16'h0000;
      cau_s1 <= 16'h0000;
      cau_s2 <= 16'h0000;
      cau_s3 <= 16'h0000;
    end else begin
      lvl_s1 <= INT_SOURCE_LEVELS;
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
      cau_s1 <= SHUTDOWN_CAUSES;
      cau_s2 <= cau_s1;
      cau_s3 <= cau_s2;
    end
  end

  assign lvl_rise = lvl_s2 & ~lvl_s3;
  assign cau_rise = cau_s2 & ~cau_s3;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge CLOCK) begin
    if (RESET || soft_reset) begin
      status_reg <= cpcr_pkg::STATUS_RESET;
    end else begin
      status_reg <= (status_reg & ~((wr_now && addr_reg == cpcr_pkg::IDX_INT_STATUS) ?
                    HWDATA[15:0] : 16'h0000)) | lvl_rise;
    end
  end

  // Each new shutdown replaces the record of the previous one
  always_ff @(posedge CLOCK) begin
    if (RESET || soft_reset) begin
      cause_reg <= cpcr_pkg::CAUSE_RESET;
    end else if (|cau_rise) begin
      cause_reg <= cau_rise;
    end
  end

  // A set mask bit blocks its status bit from the interrupt line
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & ~mask_reg);
    end
  end

  assign IRQ = irq_reg;

  ////////////////////////////////////////////////////////////////
  // Checks

  // Soft reset returns the power register and holds the codec
  a_soft_reset_power: assert property (@(posedge CLOCK) disable iff (RESET)
    soft_reset |=> (power_reg == cpcr_pkg::POWER_RESET) && CODEC_REG_RESET)
    else $error("power register not cleared by soft reset");

  // Soft reset also empties mask, sticky status and shutdown record
  a_soft_reset_rest: assert property (@(posedge CLOCK) disable iff (RESET)
    soft_reset |=> mask_reg == cpcr_pkg::MASK_RESET && status_reg == cpcr_pkg::STATUS_RESET
    && cause_reg == cpcr_pkg::CAUSE_RESET)
    else $error("registers not cleared by soft reset");

  // Identity reads come out of the wait cycle; ready checked on the device code read
  a_device_code_read: assert property (@(posedge CLOCK) disable iff (RESET)
    (bus_reg == cpcr_pkg::BUS_READ_WAIT && addr_ok_reg && addr_reg == 8'h00)
    |=> HRDATA == {16'h0000, cpcr_pkg::DEVICE_CODE} && HREADYOUT)
    else $error("device code read wrong");

  a_revision_read: assert property (@(posedge CLOCK) disable iff (RESET)
    (bus_reg == cpcr_pkg::BUS_READ_WAIT && addr_ok_reg && addr_reg == 8'h01)
    |=> HRDATA == ({29'h0, cpcr_pkg::SILICON_REV} << 12))
    else $error("revision read wrong");

  // Power bits and the pins decoded from them
  a_codec_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    ##1 CODEC_REG_RESET == !$past(power_next.master_codec_enable))
    else $error("codec reset not following enable");

  a_power_write: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_now && addr_reg == 8'h02) |=> power_reg == (16'hff17 & $past(HWDATA[15:0])))
    else $error("power register write lost");

  // Bias drive follows the last value written to its bit
  a_bias_hiz: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_now && addr_reg == cpcr_pkg::IDX_POWER_ONE)
    |=> MIC_BIAS_OE == $past(HWDATA[4]) && MIC_BIAS_OE == MIC_BIAS_OUT)
    else $error("mic bias drive mismatch");

  a_pair_onehot: assert property (@(posedge CLOCK) disable iff (RESET)
    $onehot0(MID_RAIL_PAIR) && MID_RAIL_PAIR == ((power_reg.mid_rail_select == 2'b00) ?
    3'b000 : 3'b001 << (power_reg.mid_rail_select - 2'b01)))
    else $error("mid-rail pair decode wrong");

  // Events, clears, mask and interrupt line
  a_event_sticky: assert property (@(posedge CLOCK) disable iff (RESET)
    (|lvl_rise && !soft_reset) |=> (status_reg & $past(lvl_rise)) == $past(lvl_rise))
    else $error("interrupt event lost");

  // A clear with no new event drops exactly the bits written as one
  a_status_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_now && addr_reg == cpcr_pkg::IDX_INT_STATUS && lvl_rise == 16'h0000)
    |=> status_reg == ($past(status_reg) & ~$past(HWDATA[15:0])))
    else $error("status clear wrong");

  a_irq_masked: assert property (@(posedge CLOCK) disable iff (RESET)
    ((status_reg & ~mask_reg) == 16'h0000) |=> !IRQ)
    else $error("masked status raised interrupt");

  a_irq_raised: assert property (@(posedge CLOCK) disable iff (RESET)
    ((status_reg & ~mask_reg) != 16'h0000) |=> IRQ)
    else $error("pending status did not raise interrupt");

  a_mask_write: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_now && addr_reg == cpcr_pkg::IDX_INT_MASK) |=> mask_reg == $past(HWDATA[15:0]))
    else $error("interrupt mask write lost");

  // Newest set of shutdown edges replaces the record
  a_cause_record: assert property (@(posedge CLOCK) disable iff (RESET)
    (|cau_rise && !soft_reset) |=> cause_reg == $past(cau_rise))
    else $error("shutdown cause not recorded");

  // Reads always insert exactly one wait state
  a_read_wait: assert property (@(posedge CLOCK) disable iff (RESET)
    (accept && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");

  c_soft_reset: cover property (@(posedge CLOCK) disable iff (RESET) soft_reset);
  c_irq_raised: cover property (@(posedge CLOCK) disable iff (RESET) $rose(IRQ));
  c_cause_rec: cover property (@(posedge CLOCK) disable iff (RESET) |cau_rise ##1 |cause_reg);
  c_status_clear: cover property (@(posedge CLOCK) disable iff (RESET)
    wr_now && addr_reg == cpcr_pkg::IDX_INT_STATUS);
  c_fast_start: cover property (@(posedge CLOCK) disable iff (RESET) MID_RAIL_PAIR == 3'b100);

endmodule // cpcr_regs

// File: testbench/cpcr_host.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Host processor side: single-word bus master
module cpcr_host (
  input wire logic CLOCK,
  input wire logic HREADY,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA,
  output logic HUNG
);
  // Idle bus from time zero
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    HUNG = 1'b0;
  end
  // Bounded wait for ready, so a stuck slave is flagged, not hung on
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge CLOCK);
    while (HREADY !== 1'b1 && n < 64) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 64) HUNG = 1'b1;
  endtask
  // One transfer; released write data shows its inverse, not a stale copy
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wdata);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {22'h0, idx, 2'h0};
    HWRITE <= wr;
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {16'h0, wdata};
    wait_ready();
    HWDATA <= ~{16'h0, wdata};
  endtask
endmodule // cpcr_host

// File: testbench/tb_codec_pmu_control_registers.sv
`timescale 1ns/1ps
////////////////////////////////////////
module tb_codec_pmu_control_registers;
  logic CLOCK, RESET, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, hung, rd_ph;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, MID_RAIL_PAIR;
  logic [15:0] INT_SOURCE_LEVELS, SHUTDOWN_CAUSES, p;
  logic CODEC_REG_RESET, SYSCLK_GATE_EN, SPK_MIXER_EN, SPK_OUTPUT_EN, AUX_OUT3_EN;
  logic AUX_OUT4_EN, HP_LEFT_EN, HP_RIGHT_EN, MIC_BIAS_OUT, MIC_BIAS_OE, ANALOGUE_REF_EN;
  logic [3:0] SHUTDOWN_ACTION, LINE_THRESH_INC, LINE_THRESH_DEC;
  logic [31:0] expq[$];
  int errors, checked;
  integer seed;

  cpcr_host u_cpcr_host (.CLOCK, .HREADY(HREADYOUT), .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HUNG(hung));
  cpcr_regs u_cpcr_regs (.CLOCK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .INT_SOURCE_LEVELS, .SHUTDOWN_CAUSES,
    .IRQ, .CODEC_REG_RESET, .SYSCLK_GATE_EN, .SPK_MIXER_EN, .SPK_OUTPUT_EN, .AUX_OUT3_EN,
    .AUX_OUT4_EN, .HP_LEFT_EN, .HP_RIGHT_EN, .MIC_BIAS_OUT, .MIC_BIAS_OE, .MID_RAIL_PAIR,
    .ANALOGUE_REF_EN, .SHUTDOWN_ACTION, .LINE_THRESH_INC, .LINE_THRESH_DEC);

  ////////////////////////////////////////
  // Clock and watchdog
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    errors++;
    wrap_up();
  end
  // A bus wait that ran out of bound ends the run at once
  always @(posedge hung) begin
    errors++;
    wrap_up();
  end

  task automatic wrap_up();
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  ////////////////////////////////////////
  // Read data is taken when ready ends the read data phase
  always @(posedge CLOCK) begin
    if (rd_ph && HREADYOUT === 1'b1) begin
      if (expq.size() == 0) compare("unexpected read", 32'h0, 32'h1);
      else compare("read data", expq.pop_front(), HRDATA);
    end
    if (HREADYOUT === 1'b1) rd_ph <= HSEL && HTRANS[1] && !HWRITE;
  end

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    expq.push_back(exp);
    u_cpcr_host.xfer(1'b0, idx, 16'h0);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    u_cpcr_host.xfer(1'b1, idx, d);
  endtask
  // Pin image of a power value; mid-rail code maps to a one-hot pair
  task automatic chk_pins(input logic [15:0] v);
    logic [2:0] pair;
    pair = (v[2:1] == 2'h0) ? 3'h0 : 3'h1 << (v[2:1] - 2'h1);
    @(negedge CLOCK);
    compare("pins", {18'h0, ~v[15], v[14:8], v[4], v[4], pair, v[0]}, {18'h0,
      CODEC_REG_RESET, SYSCLK_GATE_EN, SPK_MIXER_EN, SPK_OUTPUT_EN, AUX_OUT3_EN, AUX_OUT4_EN,
      HP_LEFT_EN, HP_RIGHT_EN, MIC_BIAS_OUT, MIC_BIAS_OE, MID_RAIL_PAIR, ANALOGUE_REF_EN});
  endtask
  task automatic pulse_in(input logic [15:0] lv, input logic [15:0] sc);
    @(posedge CLOCK);
    INT_SOURCE_LEVELS <= lv;
    SHUTDOWN_CAUSES <= sc;
    repeat (6) @(posedge CLOCK);
  endtask

  ////////////////////////////////////////
  initial begin
    seed = 32'hce73;
    errors = 0;
    checked = 0;
    rd_ph = 1'b0;
    RESET = 1'b1;
    INT_SOURCE_LEVELS = 16'h0;
    SHUTDOWN_CAUSES = 16'h0;
    repeat (8) @(posedge CLOCK);
    RESET <= 1'b0;
    chk_pins(16'h0);
    rd(cpcr_pkg::IDX_RESET_ID, {16'h0, cpcr_pkg::DEVICE_CODE});
    wr(cpcr_pkg::IDX_REVISION, 16'h7000);
    rd(cpcr_pkg::IDX_REVISION, {17'h0, cpcr_pkg::SILICON_REV, 12'h0});
    // Every mid-rail code, random enables, reserved bits kept at default
    for (int i = 0; i < 8; i++) begin
      p = 16'($random(seed)) & cpcr_pkg::POWER_WMASK;
      p[2:1] = i[1:0];
      wr(cpcr_pkg::IDX_POWER_ONE, p);
      chk_pins(p);
      rd(cpcr_pkg::IDX_POWER_ONE, {16'h0, p});
    end
    p = 16'($random(seed)) & (cpcr_pkg::SHUTDOWN_WMASK | cpcr_pkg::LINE_WMASK);
    wr(cpcr_pkg::IDX_SHUTDOWN_CTRL, p & cpcr_pkg::SHUTDOWN_WMASK);
    wr(cpcr_pkg::IDX_LINE_THRESH, p & cpcr_pkg::LINE_WMASK);
    @(negedge CLOCK);
    compare("thresholds", {20'h0, p[9:6], p[7:0]}, {20'h0, SHUTDOWN_ACTION,
      LINE_THRESH_INC, LINE_THRESH_DEC});
    // Unmasked source latches and raises the interrupt; mask hides it
    wr(cpcr_pkg::IDX_INT_MASK, 16'h0);
    pulse_in(16'h8001, 16'h0);
    rd(cpcr_pkg::IDX_INT_STATUS, 32'h8001);
    rd(cpcr_pkg::IDX_INT_LEVELS, 32'h8001);
    @(negedge CLOCK);
    compare("irq", 32'h1, {31'h0, IRQ});
    wr(cpcr_pkg::IDX_INT_MASK, 16'hffff);
    repeat (2) @(negedge CLOCK);
    compare("irq", 32'h0, {31'h0, IRQ});
    rd(cpcr_pkg::IDX_INT_MASK, 32'hffff);
    pulse_in(16'h0, 16'h2040);
    rd(cpcr_pkg::IDX_INT_STATUS, 32'h8001);
    rd(cpcr_pkg::IDX_INT_LEVELS, 32'h0);
    rd(cpcr_pkg::IDX_SHUTDOWN_CAUSE, 32'h2040);
    wr(cpcr_pkg::IDX_INT_STATUS, 16'h8000);
    rd(cpcr_pkg::IDX_INT_STATUS, 32'h0001);
    pulse_in(16'h0, 16'h2840);
    rd(cpcr_pkg::IDX_SHUTDOWN_CAUSE, 32'h0800);
    // Soft reset with random data clears everything but the identity
    wr(cpcr_pkg::IDX_RESET_ID, 16'($random(seed)));
    chk_pins(16'h0);
    rd(cpcr_pkg::IDX_POWER_ONE, 32'h0);
    rd(cpcr_pkg::IDX_INT_MASK, 32'h0);
    rd(cpcr_pkg::IDX_INT_STATUS, 32'h0);
    rd(cpcr_pkg::IDX_SHUTDOWN_CAUSE, 32'h0);
    rd(cpcr_pkg::IDX_RESET_ID, {16'h0, cpcr_pkg::DEVICE_CODE});
    rd(cpcr_pkg::IDX_RSVD_4D, 32'h0);
    rd(cpcr_pkg::IDX_RSVD_53, 32'h0);
    rd(8'hff, 32'h0);
    repeat (4) @(posedge CLOCK);
    compare("pending reads", 32'h0, expq.size());
    compare("bus", 32'h0, {30'h0, hung, HRESP});
    wrap_up();
  end
endmodule // tb_codec_pmu_control_registers
